// File: src/line_card_slave_control_port.sv
// Slave-mode parallel control port of a subscriber line interface device.
`timescale 1ns/1ns
module line_card_slave_control_port
  import line_card_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       mode_bit_0_i,
  input  wire logic       mode_bit_1_i,
  input  wire logic       mode_bit_2_i,
  input  wire logic       test_relay_bit_a_i,
  input  wire logic       test_relay_bit_b_i,
  input  wire logic       input_chip_select_n_i,
  input  wire logic       output_chip_select_n_i,
  input  wire logic       device_reset_n_i,
  input  wire logic       mode_select_i,
  input  wire logic       ring_sync_clock_i,
  input  wire logic       off_hook_det_i,
  input  wire logic       ring_trip_det_i,
  input  wire logic       ground_key_det_i,
  input  wire logic       thermal_alarm_i,
  input  wire logic       line_fault_i,
  input  wire logic       ring_grounded_i,
  output logic            hook_status_n_o,
  output logic            hook_status_n_oe_o,
  output logic            groundkey_alarm_n_o,
  output logic            groundkey_alarm_n_oe_o,
  output logic            ringer_relay_drive_o,
  output logic            test_relay_drive_a_o,
  output logic            test_relay_drive_b_o,
  output logic            ring_trip_latched_o,
  output logic [2:0]      op_mode_o
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;

  assign pins_raw[P_MODE_BIT_0]  = mode_bit_0_i;
  assign pins_raw[P_MODE_BIT_1]  = mode_bit_1_i;
  assign pins_raw[P_MODE_BIT_2]  = mode_bit_2_i;
  assign pins_raw[P_RELAY_A]     = test_relay_bit_a_i;
  assign pins_raw[P_RELAY_B]     = test_relay_bit_b_i;
  assign pins_raw[P_CS_IN_N]     = input_chip_select_n_i;
  assign pins_raw[P_CS_OUT_N]    = output_chip_select_n_i;
  assign pins_raw[P_DEV_RESET_N] = device_reset_n_i;
  assign pins_raw[P_MODE_SELECT] = mode_select_i;
  assign pins_raw[P_RING_SYNC]   = ring_sync_clock_i;
  assign pins_raw[P_OFF_HOOK]    = off_hook_det_i;
  assign pins_raw[P_RING_TRIP]   = ring_trip_det_i;
  assign pins_raw[P_GROUND_KEY]  = ground_key_det_i;
  assign pins_raw[P_THERMAL]     = thermal_alarm_i;
  assign pins_raw[P_LINE_FAULT]  = line_fault_i;
  assign pins_raw[P_RING_GROUND] = ring_grounded_i;

  pin_sync #(
    .WIDTH   (PIN_W),
    .RST_VAL (PIN_RST)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins_i     (pins_raw),
    .pins_o     (pins_s)
  );

  logic [2:0] s_code;
  logic       s_relay_a;
  logic       s_relay_b;
  logic       s_cs_in_n;
  logic       s_cs_out_n;
  logic       dev_rst;
  logic       s_auto_mode;
  logic       s_ring_sync;
  logic       s_off_hook;
  logic       s_ring_trip;
  logic       s_ground_key;
  logic       s_thermal;
  logic       s_line_fault;
  logic       s_ring_ground;

  assign s_code        = {pins_s[P_MODE_BIT_0], pins_s[P_MODE_BIT_1], pins_s[P_MODE_BIT_2]};
  assign s_relay_a     = pins_s[P_RELAY_A];
  assign s_relay_b     = pins_s[P_RELAY_B];
  assign s_cs_in_n     = pins_s[P_CS_IN_N];
  assign s_cs_out_n    = pins_s[P_CS_OUT_N];
  assign dev_rst       = !pins_s[P_DEV_RESET_N];
  assign s_auto_mode   = pins_s[P_MODE_SELECT];
  assign s_ring_sync   = pins_s[P_RING_SYNC];
  assign s_off_hook    = pins_s[P_OFF_HOOK];
  assign s_ring_trip   = pins_s[P_RING_TRIP];
  assign s_ground_key  = pins_s[P_GROUND_KEY];
  assign s_thermal     = pins_s[P_THERMAL];
  assign s_line_fault  = pins_s[P_LINE_FAULT];
  assign s_ring_ground = pins_s[P_RING_GROUND];

  // ---------------------------------------------------------------------------
  // Mode decoding
  // ---------------------------------------------------------------------------
  function automatic op_mode_t decode_mode(input logic [2:0] code);
    op_mode_t m;
    m = POWER_DOWN;
    case (code)
      CODE_POWER_DOWN: m = POWER_DOWN;
      CODE_STAND_BY:   m = STAND_BY;
      CODE_ACTIVE_NP:  m = ACTIVE_NP;
      CODE_ACTIVE_RP:  m = ACTIVE_RP;
      CODE_RING_NP:    m = RING_NP;
      CODE_RING_RP:    m = RING_RP;
      CODE_GND_START:  m = GROUND_START;
      CODE_HI_Z_FEED:  m = HI_Z_FEED;
      default:         m = POWER_DOWN;
    endcase
    return m;
  endfunction : decode_mode

  function automatic logic is_ringing(input op_mode_t m);
    return (m == RING_NP) || (m == RING_RP);
  endfunction : is_ringing

  // ---------------------------------------------------------------------------
  // Input latches
  // ---------------------------------------------------------------------------
  logic [2:0] mode_code_r;
  logic [2:0] prev_code_r;
  logic       relay_a_r;
  logic       relay_b_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || dev_rst) begin
      mode_code_r <= MODE_CODE_RST;
      relay_a_r   <= RELAY_RST;
      relay_b_r   <= RELAY_RST;
    end else if (!s_cs_in_n) begin
      mode_code_r <= s_code;
      relay_a_r   <= s_relay_a;
      relay_b_r   <= s_relay_b;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prev_code_r <= MODE_CODE_RST;
    end else begin
      prev_code_r <= mode_code_r;
    end
  end

  op_mode_t op_mode;
  logic     mode_changed;
  logic     ringing;

  // Automatic activation is not provided, so that setting idles in power-down.
  assign op_mode      = s_auto_mode ? POWER_DOWN : decode_mode(mode_code_r);
  assign mode_changed = (mode_code_r != prev_code_r);
  assign ringing      = is_ringing(op_mode);

  // ---------------------------------------------------------------------------
  // Ring-trip latch and ringer relay
  // ---------------------------------------------------------------------------
  logic trip_latched_r;
  logic ringer_r;
  logic ring_request;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || dev_rst) begin
      trip_latched_r <= 1'h0;
    end else if (ringing && s_ring_trip) begin
      trip_latched_r <= 1'h1;
    end else if (mode_changed || !ringing) begin
      trip_latched_r <= 1'h0;
    end
  end

  assign ring_request = ringing && !trip_latched_r && !s_thermal && !dev_rst;

  // Once on, the relay stays on through high clock phases; a steady low clock
  // lets the relay follow the request at once.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ringer_r <= 1'h0;
    end else begin
      ringer_r <= ring_request && (ringer_r || !s_ring_sync);
    end
  end

  // ---------------------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------------------
  logic hook_n_nxt;
  logic gk_n_nxt;
  logic hook_n_r;
  logic gk_n_r;
  logic status_oe_r;

  always_comb begin
    hook_n_nxt = 1'h1;
    gk_n_nxt   = 1'h1;
    if (dev_rst) begin
      hook_n_nxt = 1'h1;
      gk_n_nxt   = 1'h1;
    end else if (s_thermal) begin
      hook_n_nxt = 1'h0;
      gk_n_nxt   = 1'h0;
    end else begin
      case (op_mode)
        POWER_DOWN: begin
          hook_n_nxt = 1'h1;
          gk_n_nxt   = 1'h1;
        end
        STAND_BY, ACTIVE_NP, ACTIVE_RP: begin
          hook_n_nxt = !s_off_hook;
          gk_n_nxt   = !(s_ground_key || s_line_fault);
        end
        RING_NP, RING_RP: begin
          hook_n_nxt = !trip_latched_r;
          gk_n_nxt   = 1'h1;
        end
        GROUND_START: begin
          if (s_ring_ground) begin
            hook_n_nxt = !s_off_hook;
            gk_n_nxt   = !(s_ground_key || s_line_fault);
          end
        end
        HI_Z_FEED: begin
          hook_n_nxt = !s_off_hook;
          gk_n_nxt   = 1'h1;
        end
        default: begin
          hook_n_nxt = 1'h1;
          gk_n_nxt   = 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hook_n_r <= 1'h1;
      gk_n_r   <= 1'h1;
    end else begin
      hook_n_r <= hook_n_nxt;
      gk_n_r   <= gk_n_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_oe_r <= 1'h0;
    end else begin
      status_oe_r <= !s_cs_out_n;
    end
  end

  // ---------------------------------------------------------------------------
  // Relay drivers and observation outputs
  // ---------------------------------------------------------------------------
  logic       relay_drive_a_r;
  logic       relay_drive_b_r;
  logic [2:0] op_mode_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || dev_rst) begin
      relay_drive_a_r <= 1'h0;
      relay_drive_b_r <= 1'h0;
    end else begin
      relay_drive_a_r <= relay_a_r;
      relay_drive_b_r <= relay_b_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      op_mode_r <= 3'h0;
    end else begin
      op_mode_r <= op_mode;
    end
  end

  assign hook_status_n_o        = hook_n_r;
  assign groundkey_alarm_n_o    = gk_n_r;
  assign hook_status_n_oe_o     = status_oe_r;
  assign groundkey_alarm_n_oe_o = status_oe_r;
  assign ringer_relay_drive_o   = ringer_r;
  assign test_relay_drive_a_o   = relay_drive_a_r;
  assign test_relay_drive_b_o   = relay_drive_b_r;
  assign ring_trip_latched_o    = trip_latched_r;
  assign op_mode_o              = op_mode_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  status_float_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_cs_out_n |=> !hook_status_n_oe_o && !groundkey_alarm_n_oe_o)
    else $error("Status outputs driven while output select high.");

  latch_capture_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!s_cs_in_n && !dev_rst) |=> (mode_code_r == $past(s_code)) && (relay_a_r == $past(s_relay_a)))
    else $error("Input latch did not capture the bus.");

  latch_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_cs_in_n && !dev_rst) |=> $stable(mode_code_r) && $stable(relay_b_r))
    else $error("Input latch changed while select high.");

  relay_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!dev_rst && !s_cs_in_n) ##1 !dev_rst |=> (test_relay_drive_a_o == $past(s_relay_a, 2)))
    else $error("Test relay driver does not follow its bit.");

  reset_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    dev_rst |=> !test_relay_drive_a_o && !test_relay_drive_b_o && hook_status_n_o
                && groundkey_alarm_n_o && !ringer_relay_drive_o)
    else $error("Reset idle state not honoured.");

  thermal_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_thermal && !dev_rst) |=> !hook_status_n_o && !groundkey_alarm_n_o && !ringer_relay_drive_o)
    else $error("Thermal alarm did not force status low.");

  ringer_sync_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(ringer_relay_drive_o) |-> $past(!s_ring_sync) && $past(ringing))
    else $error("Ringer relay turned on outside a low clock phase.");

  ringer_on_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ring_request && !s_ring_sync) |=> ringer_relay_drive_o)
    else $error("Ringer relay not activated in ringing.");

  trip_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ringing && s_ring_trip && !dev_rst) |=> ##1 !ringer_relay_drive_o && !hook_status_n_o)
    else $error("Ring-trip did not release ringer and pull hook low.");

  trip_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (trip_latched_r && ringing && !mode_changed && !dev_rst) |=> trip_latched_r)
    else $error("Ring-trip latch dropped without a mode change.");

  power_down_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (op_mode == POWER_DOWN && !s_thermal) |=> hook_status_n_o && groundkey_alarm_n_o
                                             && !ringer_relay_drive_o)
    else $error("Power-down left a function enabled.");

  ringing_gk_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ringing && !s_thermal) |=> groundkey_alarm_n_o)
    else $error("Ground-key output active while ringing.");

endmodule : line_card_slave_control_port

// File: src/line_card_pkg.sv
// Package with constants and types for the line card slave control port.
package line_card_pkg;

  // ---------------------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    POWER_DOWN,
    STAND_BY,
    ACTIVE_NP,
    ACTIVE_RP,
    RING_NP,
    RING_RP,
    GROUND_START,
    HI_Z_FEED
  } op_mode_t;

  localparam int          MODE_W          = 3;
  localparam logic [2:0]  CODE_POWER_DOWN = 3'h0;
  localparam logic [2:0]  CODE_STAND_BY   = 3'h1;
  localparam logic [2:0]  CODE_ACTIVE_NP  = 3'h2;
  localparam logic [2:0]  CODE_ACTIVE_RP  = 3'h3;
  localparam logic [2:0]  CODE_RING_NP    = 3'h4;
  localparam logic [2:0]  CODE_RING_RP    = 3'h5;
  localparam logic [2:0]  CODE_GND_START  = 3'h6;
  localparam logic [2:0]  CODE_HI_Z_FEED  = 3'h7;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  MODE_CODE_RST   = CODE_POWER_DOWN;
  localparam logic        RELAY_RST       = 1'h0;

  // ---------------------------------------------------------------------------
  // Positions of the pins in the synchronised input vector
  // ---------------------------------------------------------------------------
  localparam int          PIN_W           = 16;
  localparam int          P_MODE_BIT_0    = 0;
  localparam int          P_MODE_BIT_1    = 1;
  localparam int          P_MODE_BIT_2    = 2;
  localparam int          P_RELAY_A       = 3;
  localparam int          P_RELAY_B       = 4;
  localparam int          P_CS_IN_N       = 5;
  localparam int          P_CS_OUT_N      = 6;
  localparam int          P_DEV_RESET_N   = 7;
  localparam int          P_MODE_SELECT   = 8;
  localparam int          P_RING_SYNC     = 9;
  localparam int          P_OFF_HOOK      = 10;
  localparam int          P_RING_TRIP     = 11;
  localparam int          P_GROUND_KEY    = 12;
  localparam int          P_THERMAL       = 13;
  localparam int          P_LINE_FAULT    = 14;
  localparam int          P_RING_GROUND   = 15;
  localparam logic [15:0] PIN_RST         = 16'h00E0;

endpackage : line_card_pkg

// File: src/pin_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/1ns
module pin_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] pins_o
);

  logic [WIDTH-1:0] meta_r;

  // ---------------------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      pins_o <= RST_VAL;
    end else begin
      meta_r <= pins_i;
      pins_o <= meta_r;
    end
  end

endmodule : pin_sync

// File: test/line_card_ctl_model.sv
// Behavioural line card controller that drives the parallel control bus.
`timescale 1ns/1ns
module line_card_ctl_model (
  input  wire logic core_clk_i,
  output logic      mode_bit_0_o,
  output logic      mode_bit_1_o,
  output logic      mode_bit_2_o,
  output logic      test_relay_bit_a_o,
  output logic      test_relay_bit_b_o,
  output logic      input_chip_select_n_o,
  output logic      output_chip_select_n_o,
  output logic      device_reset_n_o,
  output logic      ring_sync_clock_o
);
  // ---------------------------------------------------------------------------
  // Idle bus: released lines sit at the pull-down level, selects inactive.
  // ---------------------------------------------------------------------------
  initial begin
    {mode_bit_0_o, mode_bit_1_o, mode_bit_2_o} = 3'h0;
    {test_relay_bit_a_o, test_relay_bit_b_o}   = 2'h0;
    input_chip_select_n_o  = 1'b1;
    output_chip_select_n_o = 1'b1;
    device_reset_n_o       = 1'b1;
    ring_sync_clock_o      = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  task automatic write_word(input logic [2:0] code, input logic ra, input logic rb);
    @(negedge core_clk_i);
    {mode_bit_0_o, mode_bit_1_o, mode_bit_2_o} = code;
    {test_relay_bit_a_o, test_relay_bit_b_o}   = {ra, rb};
    input_chip_select_n_o = 1'b0;
    repeat (3) @(negedge core_clk_i);
    input_chip_select_n_o = 1'b1;
    repeat (3) @(negedge core_clk_i);
    {mode_bit_0_o, mode_bit_1_o, mode_bit_2_o} = 3'h0;
    {test_relay_bit_a_o, test_relay_bit_b_o}   = 2'h0;
  endtask : write_word

  task automatic set_out_select_n(input logic v);
    @(negedge core_clk_i);
    output_chip_select_n_o = v;
  endtask : set_out_select_n

  task automatic set_dev_reset_n(input logic v);
    @(negedge core_clk_i);
    device_reset_n_o = v;
  endtask : set_dev_reset_n

  // The caller keeps each low phase at least 20 cycles long.
  task automatic set_sync(input logic v);
    @(negedge core_clk_i);
    ring_sync_clock_o = v;
  endtask : set_sync
endmodule : line_card_ctl_model

// File: test/line_card_slave_control_port_bench.sv
// Self-checking testbench for the line card slave control port.
`timescale 1ns/1ns
module line_card_slave_control_port_bench;
  import line_card_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        mode_sel;
  logic        off_hook;
  logic        trip;
  logic        gkey;
  logic        therm;
  logic        fault;
  logic        ring_gnd;
  logic        trip_lat   = 1'b0;
  logic        sync_lvl   = 1'b0;
  logic        oe_on      = 1'b0;
  logic [2:0]  cur_code   = 3'h0;
  logic        cur_ra     = 1'b0;
  logic        cur_rb     = 1'b0;
  logic [31:0] rnd;
  logic [9:0]  seen;
  logic [9:0]  exp_v;
  logic [9:0]  exp_q[$];
  int          seed        = 4;
  int          errors      = 0;
  int          check_count = 0;
  event        sample_ev;
  wire         m0, m1, m2, ra, rb, cs_in_n, cs_out_n, dev_rst_n, sync;
  wire         hook_n, hook_oe, gk_n, gk_oe, ringer, rel_a, rel_b, trip_w;
  wire [2:0]   op_mode;

  always #25 core_clk_i = ~core_clk_i;

  line_card_ctl_model ctl (
    .core_clk_i(core_clk_i), .mode_bit_0_o(m0), .mode_bit_1_o(m1), .mode_bit_2_o(m2),
    .test_relay_bit_a_o(ra), .test_relay_bit_b_o(rb), .input_chip_select_n_o(cs_in_n),
    .output_chip_select_n_o(cs_out_n), .device_reset_n_o(dev_rst_n),
    .ring_sync_clock_o(sync));

  line_card_slave_control_port dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .mode_bit_0_i(m0), .mode_bit_1_i(m1),
    .mode_bit_2_i(m2), .test_relay_bit_a_i(ra), .test_relay_bit_b_i(rb),
    .input_chip_select_n_i(cs_in_n), .output_chip_select_n_i(cs_out_n),
    .device_reset_n_i(dev_rst_n), .mode_select_i(mode_sel), .ring_sync_clock_i(sync),
    .off_hook_det_i(off_hook), .ring_trip_det_i(trip), .ground_key_det_i(gkey),
    .thermal_alarm_i(therm), .line_fault_i(fault), .ring_grounded_i(ring_gnd),
    .hook_status_n_o(hook_n), .hook_status_n_oe_o(hook_oe), .groundkey_alarm_n_o(gk_n),
    .groundkey_alarm_n_oe_o(gk_oe), .ringer_relay_drive_o(ringer),
    .test_relay_drive_a_o(rel_a), .test_relay_drive_b_o(rel_b),
    .ring_trip_latched_o(trip_w), .op_mode_o(op_mode));

  // ---------------------------------------------------------------------------
  // Expected outputs: {oe, hook_n, gk_n, ringer, trip, relay_a, relay_b, op_mode}.
  // ---------------------------------------------------------------------------
  function automatic logic [9:0] model(input logic [2:0] c, input logic r_a, input logic r_b);
    logic h;
    logic g;
    logic r;
    h = 1'b1;
    g = 1'b1;
    r = 1'b0;
    case (c)
      CODE_STAND_BY, CODE_ACTIVE_NP, CODE_ACTIVE_RP: begin
        h = ~off_hook;
        g = ~(gkey | fault);
      end
      CODE_HI_Z_FEED: h = ~off_hook;
      CODE_RING_NP, CODE_RING_RP: begin
        h = ~trip_lat;
        r = ~trip_lat & ~sync_lvl;
      end
      CODE_GND_START: if (ring_gnd) begin
        h = ~off_hook;
        g = ~(gkey | fault);
      end
      default: h = 1'b1;
    endcase
    if (therm) begin
      h = 1'b0;
      g = 1'b0;
      r = 1'b0;
    end
    if (!oe_on) begin
      h = 1'b1;
      g = 1'b1;
    end
    return {oe_on, h, g, r, trip_lat, r_a, r_b, c};
  endfunction : model

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [9:0] s, input logic [9:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, e, s);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : step

  task automatic apply(input logic [2:0] c, input logic r_a, input logic r_b);
    cur_code = c;
    cur_ra   = r_a;
    cur_rb   = r_b;
    ctl.write_word(c, r_a, r_b);
    step(2);
  endtask : apply

  task automatic expect_vec(input logic [9:0] v);
    exp_q.push_back(v);
    -> sample_ev;
    step(1);
  endtask : expect_vec

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------------------
  // Monitor: compares the settled outputs with the oldest expectation.
  // ---------------------------------------------------------------------------
  always @(sample_ev) begin
    exp_v = exp_q.pop_front();
    seen  = {hook_oe, hook_n, gk_n, ringer, trip_w, rel_a, rel_b, op_mode};
    if (hook_oe === 1'b0 && gk_oe === 1'b0) begin
      seen[8:7] = 2'b11;
    end
    if (gk_oe !== hook_oe) begin
      seen[9] = 1'bx;
    end
    check("outputs", seen, exp_v);
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    wrap_up();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {mode_sel, off_hook, trip, gkey, therm, fault, ring_gnd} = 7'h00;
    step(5);
    rst_i = 1'b0;
    ctl.set_out_select_n(1'b0);
    oe_on = 1'b1;
    step(6);
    expect_vec(model(3'h0, 1'b0, 1'b0));
    $display("Test reset done");
    for (int i = 0; i < 16; i++) begin
      rnd      = $random(seed);
      off_hook = rnd[0];
      gkey     = rnd[1];
      ring_gnd = rnd[2];
      fault    = rnd[5];
      apply(i[2:0], rnd[3], rnd[4]);
      expect_vec(model(cur_code, cur_ra, cur_rb));
      expect_vec(model(cur_code, cur_ra, cur_rb));
    end
    $display("Test mode decode done");
    ctl.set_out_select_n(1'b1);
    oe_on = 1'b0;
    step(4);
    expect_vec(model(cur_code, cur_ra, cur_rb));
    ctl.set_out_select_n(1'b0);
    oe_on = 1'b1;
    off_hook = 1'b0;
    ctl.set_sync(1'b1);
    sync_lvl = 1'b1;
    apply(CODE_RING_NP, 1'b1, 1'b0);
    step(2);
    expect_vec(model(cur_code, cur_ra, cur_rb));
    ctl.set_sync(1'b0);
    sync_lvl = 1'b0;
    step(4);
    expect_vec(model(cur_code, cur_ra, cur_rb));
    step(20);
    $display("Test ring sync done");
    trip = 1'b1;
    step(4);
    trip = 1'b0;
    trip_lat = 1'b1;
    step(4);
    expect_vec(model(cur_code, cur_ra, cur_rb));
    step(10);
    expect_vec(model(cur_code, cur_ra, cur_rb));
    apply(CODE_RING_RP, 1'b1, 1'b0);
    trip_lat = 1'b0;
    step(2);
    expect_vec(model(cur_code, cur_ra, cur_rb));
    $display("Test ring trip done");
    apply(CODE_STAND_BY, 1'b1, 1'b1);
    therm = 1'b1;
    step(5);
    expect_vec(model(cur_code, cur_ra, cur_rb));
    therm = 1'b0;
    fault = 1'b1;
    step(5);
    expect_vec(model(cur_code, cur_ra, cur_rb));
    fault = 1'b0;
    $display("Test alarm done");
    ctl.set_dev_reset_n(1'b0);
    step(5);
    expect_vec(model(3'h0, 1'b0, 1'b0));
    ctl.set_dev_reset_n(1'b1);
    step(5);
    expect_vec(model(3'h0, 1'b0, 1'b0));
    apply(CODE_ACTIVE_NP, 1'b0, 1'b0);
    mode_sel = 1'b1;
    step(5);
    expect_vec(model(3'h0, 1'b0, 1'b0));
    mode_sel = 1'b0;
    step(5);
    expect_vec(model(CODE_ACTIVE_NP, 1'b0, 1'b0));
    $display("Test reset pin and mode select done");
    step(2);
    wrap_up();
  end
endmodule : line_card_slave_control_port_bench
